// ### core/spc_pkg.sv
// Shared constants and helpers for the SPI pin and register block
package spc_pkg;

   // ==========================================
   // Register indices on the local register port
   localparam logic [1:0] REG_CTRL = 2'h0;   // Control register
   localparam logic [1:0] REG_STAT = 2'h1;   // Status and control register
   localparam logic [1:0] REG_DATA = 2'h2;   // Data register

   // ==========================================
   // Control register bit positions
   localparam int C_RXIE = 7;   // Receive request enable
   localparam int C_MSTR = 5;   // Master select
   localparam int C_CPOL = 4;   // Clock polarity
   localparam int C_CPHA = 3;   // Clock phase
   localparam int C_WOM  = 2;   // Wired-OR mode
   localparam int C_SPE  = 1;   // Module enable
   localparam int C_TXIE = 0;   // Transmit request enable

   // ==========================================
   // Status and control register bit positions
   localparam int S_RF    = 7;  // Receiver full
   localparam int S_ERROR_IRQ_ENABLE = 6;  // Error request enable
   localparam int S_OV    = 5;  // Overflow
   localparam int S_MF    = 4;  // Mode fault
   localparam int S_TE    = 3;  // Transmitter empty
   localparam int S_MFEN  = 2;  // Mode fault enable
   localparam int S_RATE  = 0;  // Rate select, two bits

   // ==========================================
   // Reset values and counts
   localparam logic [7:0] CTRL_RST  = 8'h28;  // Master set, phase set
   localparam logic [7:0] STAT_RST  = 8'h08;  // Transmitter empty set
   localparam logic [3:0] LAST_EDGE = 4'hf;   // Sixteen edges make one byte
   localparam logic [7:0] PEER_HALF = 8'h04;  // Peer half period in clocks
   localparam logic [7:0] IDLE_FILL = 8'hff;  // Sent by the peer as slave with nothing queued
   localparam int         CLK_HZ    = 10_000_000;

   // ==========================================
   // Rate code to divisor: half period in base clocks
   function automatic logic [7:0] spc_rate_div(input logic [1:0] code);
      case (code)
         2'h0:    spc_rate_div = 8'h02;
         2'h1:    spc_rate_div = 8'h08;
         2'h2:    spc_rate_div = 8'h20;
         default: spc_rate_div = 8'h80;
      endcase
   endfunction : spc_rate_div

   // One clock edge: state is {shift, sampled bit, data out}
   function automatic logic [9:0] spc_step(input logic [9:0] s, input logic cpha,
                                           input logic lead, input logic din);
      spc_step = s;
      if (!cpha && lead) spc_step[1] = din;                            // Sample first
      else if (!cpha) spc_step = {s[8:2], s[1], s[8], s[8]};           // Shift, next bit out
      else if (lead) spc_step[0] = s[9];                               // Bit out first
      else spc_step[9:2] = {s[8:2], din};                              // Then sample in
   endfunction : spc_step

   // Pin drive {out, enable}; open drain only ever pulls low
   function automatic logic [1:0] spc_drive(input logic own, input logic wom, input logic d);
      spc_drive = {d & ~wom, own & (~wom | ~d)};
   endfunction : spc_drive

endpackage : spc_pkg

// ### core/spc_link_if.sv
// Serial link wires between the documented device and its peer
`timescale 1ns/1ns
`default_nettype none
interface spc_link_if;
   // ==========================================
   // Drives from the device end
   logic dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe;
   logic dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
   // Drives from the peer end
   logic peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe;
   logic peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe;
   // Resolved line levels, pulled high when nobody pulls low
   logic sclk, mosi, miso, ss_n;
   assign sclk = ~((dev_sclk_oe & ~dev_sclk_o) | (peer_sclk_oe & ~peer_sclk_o));
   assign mosi = ~((dev_mosi_oe & ~dev_mosi_o) | (peer_mosi_oe & ~peer_mosi_o));
   assign miso = ~((dev_miso_oe & ~dev_miso_o) | (peer_miso_oe & ~peer_miso_o));
   assign ss_n = ~((dev_ss_oe & ~dev_ss_o) | (peer_ss_oe & ~peer_ss_o));
   // ==========================================
   // One modport per party
   modport dev (output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
                output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
                input sclk, mosi, miso, ss_n);
   modport peer (output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe,
                 output peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe,
                 input sclk, mosi, miso, ss_n);
endinterface : spc_link_if
`default_nettype wire

// ### core/spc_device.sv
// SPI device end: control, status and data registers with pin control
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - One byte per eight serial clock cycles
// - Master drives clock pin, slave reads it
// - Phase 0: select toggles between every byte
// - Phase 1: select may stay low
// - Slave select is always input as slave
// - Deselected slave: output off, edges ignored
// - Master select pin used only with fault enable
// - Disabled: select pin ignored entirely
// - Byte received sets receiver full, request
// - Full clears by status then data read
// - Empty set on load, cleared by write
// - Write data only while empty, no RMW
// - Overflow keeps old byte, drops new
// - Mode fault on bad select level
// - Fault clears by status read, control write
// - Error enable gates overflow and fault requests
// - Master select bit, set by reset
// - Polarity, phase equal; reset polarity 0, phase 1
// - Wired-OR makes pins open drain
// - Enable bit; clearing causes partial reset
// - Rate field picks divisor 2/8/32/128
// - Data address splits transmit and receive buffers
// - Disabled: empty set, transfer aborted, pins released
module spc_device
   import spc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // Register port
   input  wire logic [1:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_wdata_in,
   output var  logic [7:0] reg_rdata_out,
   // Interrupt requests
   output var  logic       rx_irq_out,
   output var  logic       tx_irq_out,
   // Select pin as a port pin
   input  wire logic       ss_gpio_in,
   input  wire logic       ss_gpio_oe_in,
   output var  logic       ss_dedicated_out,
   // Serial link
   spc_link_if.dev         link
);

   // ==========================================
   // State
   typedef struct packed {
      logic       rxie, mstr, cpol, cpha, wom, module_enable, txie;  // Control bits
      logic       error_irq_enable, mfen;                             // Status control bits
      logic [1:0] rate;                                    // Rate select
      logic       rf, ov, mf, te;                          // Flags
      logic       rf_seen, ov_seen, mf_seen;               // First clearing step done
      logic [7:0] txbuf, rxbuf, shift;                     // Buffers and shifter
      logic       samp, dout, sclk, active, wait_hi;       // Shift engine
      logic       ss_prev, sclk_prev;                      // Last pin levels
      logic [3:0] edges;                                   // Edges seen this byte
      logic [7:0] tick;                                    // Half period counter
      logic [7:0] rdata;                                   // Read answer
      logic       sclk_o, sclk_oe, mosi_o, mosi_oe;        // Pin drives
      logic       miso_o, miso_oe, ss_o, ss_oe, ss_ded;
      logic       rx_irq, tx_irq;                          // Requests
   } spc_dev_state_type;

   spc_dev_state_type st;      // Registered state
   spc_dev_state_type n;       // Next state
   logic [7:0]        bd;      // Current rate divisor
   logic [9:0]        stp;     // Step result
   logic              do_edge; // A clock edge to act on
   logic              lead;    // Edge leaves the idle level
   logic              din;     // Serial input for this mode
   logic              load;    // Transmit buffer into shifter

   // ==========================================
   // Next state
   always_comb begin
      n       = st;
      bd      = spc_rate_div(st.rate);
      stp     = '0;
      do_edge = 1'b0;
      lead    = 1'b0;
      din     = 1'b0;
      load    = 1'b0;

      // Control register write
      if (reg_wr_in && reg_addr_in == REG_CTRL) begin
         n.rxie = reg_wdata_in[C_RXIE];
         n.mstr = reg_wdata_in[C_MSTR];
         n.cpol = reg_wdata_in[C_CPOL];
         n.cpha = reg_wdata_in[C_CPHA];
         n.wom  = reg_wdata_in[C_WOM];
         n.module_enable  = reg_wdata_in[C_SPE];
         n.txie = reg_wdata_in[C_TXIE];
         // Second step of the fault clear
         if (st.mf_seen) n.mf = 1'b0;
         n.mf_seen = 1'b0;
      end
      // Status register write, flags are read only
      if (reg_wr_in && reg_addr_in == REG_STAT) begin
         n.error_irq_enable = reg_wdata_in[S_ERROR_IRQ_ENABLE];
         n.mfen  = reg_wdata_in[S_MFEN];
         n.rate  = reg_wdata_in[S_RATE +: 2];
      end
      // Data write fills the transmit buffer only
      if (reg_wr_in && reg_addr_in == REG_DATA) begin
         n.txbuf = reg_wdata_in;
         n.te    = 1'b0;
      end

      // Register reads
      if (reg_rd_in) begin
         n.rdata = 8'h00;
         case (reg_addr_in)
            REG_CTRL: begin
               n.rdata[C_RXIE] = st.rxie;
               n.rdata[C_MSTR] = st.mstr;
               n.rdata[C_CPOL] = st.cpol;
               n.rdata[C_CPHA] = st.cpha;
               n.rdata[C_WOM]  = st.wom;
               n.rdata[C_SPE]  = st.module_enable;
               n.rdata[C_TXIE] = st.txie;
            end
            REG_STAT: begin
               n.rdata[S_RF]         = st.rf;
               n.rdata[S_ERROR_IRQ_ENABLE]      = st.error_irq_enable;
               n.rdata[S_OV]         = st.ov;
               n.rdata[S_MF]         = st.mf;
               n.rdata[S_TE]         = st.te;
               n.rdata[S_MFEN]       = st.mfen;
               n.rdata[S_RATE +: 2]  = st.rate;
               // First clearing step remembers what was seen
               n.rf_seen = st.rf;
               n.ov_seen = st.ov;
               n.mf_seen = st.mf;
            end
            REG_DATA: begin
               n.rdata = st.rxbuf;
               // Second step clears full and overflow if the status read saw them
               if (st.rf_seen) n.rf = 1'b0;
               if (st.ov_seen) n.ov = 1'b0;
               n.rf_seen = 1'b0;
               n.ov_seen = 1'b0;
            end
            default: n.rdata = 8'h00;
         endcase
      end

      // Master engine
      if (st.module_enable && st.mstr) begin
         din  = link.miso;
         load = !st.active && !st.te;
         if (st.active) begin
            // Half period elapsed: toggle the clock
            if (st.tick == bd - 8'h01) begin
               n.tick  = 8'h00;
               n.sclk  = ~st.sclk;
               do_edge = 1'b1;
               lead    = ~st.edges[0];
            end else begin
               n.tick = st.tick + 8'h01;
            end
         end
         // Low select in a guarded master is a fault
         if (st.mfen && !link.ss_n) begin
            n.mf  = 1'b1;
            n.module_enable = 1'b0;
         end
      end else if (st.module_enable) begin
         // Slave engine, select is always an input here
         din  = link.mosi;
         lead = (link.sclk != st.cpol);
         if (link.ss_n) begin
            // Deselected: abandon the byte, ignore clocks
            if (st.active && st.mfen && !st.ss_prev) n.mf = 1'b1;
            n.active  = 1'b0;
            n.edges   = 4'h0;
            n.wait_hi = 1'b0;
         end else begin
            load    = !st.active && !st.wait_hi;
            do_edge = (link.sclk != st.sclk_prev);
         end
      end

      // Transmit buffer into shifter
      if (load) begin
         n.shift  = st.txbuf;
         n.dout   = st.txbuf[7];
         n.te     = 1'b1;
         n.active = 1'b1;
         n.tick   = 8'h00;
         n.edges  = 4'h0;
      end
      // Shift on an edge; the sixteenth ends the byte
      if (do_edge && n.active) begin
         stp                       = spc_step({n.shift, n.samp, n.dout}, st.cpha, lead, din);
         {n.shift, n.samp, n.dout} = stp;
         if (n.edges == LAST_EDGE) begin
            // Byte complete: full buffer means overflow
            if (n.rf) begin
               n.ov = 1'b1;
            end else begin
               n.rxbuf = n.shift;
               n.rf    = 1'b1;
            end
            n.active  = 1'b0;
            n.edges   = 4'h0;
            n.wait_hi = ~st.cpha & ~st.mstr;
         end else begin
            n.edges = n.edges + 4'h1;
         end
      end
      n.ss_prev   = link.ss_n;
      n.sclk_prev = link.sclk;
      // Partial reset while disabled, empty set; control bits, full, overflow and fault kept
      if (!n.module_enable) begin
         n.te      = 1'b1;
         n.active  = 1'b0;
         n.shift   = 8'h00;
         n.edges   = 4'h0;
         n.tick    = 8'h00;
         n.wait_hi = 1'b0;
      end
      // Clock idles at the polarity level
      if (!n.active) n.sclk = n.cpol;
      // System reset
      if (srst_in) begin
         n           = '0;
         n.mstr      = CTRL_RST[C_MSTR];
         n.cpol      = CTRL_RST[C_CPOL];
         n.cpha      = CTRL_RST[C_CPHA];
         n.te        = STAT_RST[S_TE];
         n.ss_prev   = 1'b1;
         n.sclk_prev = CTRL_RST[C_CPOL];
      end
      // Pin drives; enabled module owns direction
      {n.sclk_o, n.sclk_oe} = spc_drive(n.module_enable & n.mstr, n.wom, n.sclk);
      {n.mosi_o, n.mosi_oe} = spc_drive(n.module_enable & n.mstr, n.wom, n.dout);
      {n.miso_o, n.miso_oe} = spc_drive(n.module_enable & ~n.mstr & ~link.ss_n, n.wom, n.dout);
      n.ss_ded = n.module_enable & (~n.mstr | n.mfen);
      n.ss_o   = ss_gpio_in;
      n.ss_oe  = ss_gpio_oe_in & ~n.ss_ded;

      // Requests
      n.rx_irq = (n.rf & n.rxie) | ((n.ov | n.mf) & n.error_irq_enable);
      n.tx_irq = n.te & n.txie & n.module_enable;
   end
   // ==========================================
   // State register
   always_ff @(posedge clk_in) begin
      st <= n;
   end

   // ==========================================
   // Outputs straight from the state register
   assign reg_rdata_out    = st.rdata;
   assign rx_irq_out       = st.rx_irq;
   assign tx_irq_out       = st.tx_irq;
   assign ss_dedicated_out = st.ss_ded;
   assign link.dev_sclk_o  = st.sclk_o;
   assign link.dev_sclk_oe = st.sclk_oe;
   assign link.dev_mosi_o  = st.mosi_o;
   assign link.dev_mosi_oe = st.mosi_oe;
   assign link.dev_miso_o  = st.miso_o;
   assign link.dev_miso_oe = st.miso_oe;
   assign link.dev_ss_o    = st.ss_o;
   assign link.dev_ss_oe   = st.ss_oe;
endmodule : spc_device
`default_nettype wire

// ### core/spc_peer.sv
// Peer SPI end with a transmit FIFO, master or slave
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Valid/ready FIFO
module spc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   // Filling side
   input  wire logic             in_valid_in,
   output var  logic             in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Draining side
   output var  logic             out_valid_out,
   input  wire logic             out_ready_in,
   output var  logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp, rp;  // Pointers
      logic [AW:0]   cnt;     // Fill level
      logic          rdy, vld;
   } spc_fifo_state_type;

   spc_fifo_state_type st, n;
   logic [WIDTH-1:0]   mem [DEPTH];  // Storage
   logic               push, pop;

   // Pointer and level update
   always_comb begin
      n    = st;
      push = in_valid_in & st.rdy;
      pop  = out_ready_in & st.vld;
      if (push) begin
         n.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + AW'(1);
      end
      if (pop) begin
         n.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + AW'(1);
      end
      n.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      n.rdy = (n.cnt != (AW + 1)'(DEPTH));
      n.vld = (n.cnt != '0);
      if (srst_in) begin
         n     = '0;
         n.rdy = 1'b1;
      end
   end

   // State and storage
   always_ff @(posedge clk_in) begin
      st <= n;
      if (push) begin
         mem[st.wp] <= in_data_in;
      end
   end

   assign in_ready_out  = st.rdy;
   assign out_valid_out = st.vld;
   assign out_data_out  = mem[st.rp];
endmodule : spc_fifo

// ==========================================
// Peer end
module spc_peer
   import spc_pkg::*;
#(
   parameter logic [7:0] HALF  = PEER_HALF,  // Half period in clocks
   parameter int         DEPTH = 32
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // Configuration
   input  wire logic       peer_master_in,
   input  wire logic       cpol_in,
   input  wire logic       cpha_in,
   // Bytes to send
   input  wire logic       tx_valid_in,
   output var  logic       tx_ready_out,
   input  wire logic [7:0] tx_data_in,
   // Bytes received
   output var  logic       rx_valid_out,
   output var  logic [7:0] rx_data_out,
   // Serial link
   spc_link_if.peer        link
);
   typedef struct packed {
      logic [7:0] shift, rx_data, tick;
      logic       samp, dout, sclk, ss_n, active, gap, sclk_prev, rx_vld;
      logic [3:0] edges;
   } spc_peer_state_type;

   spc_peer_state_type st, n;
   logic [9:0]         stp;
   logic               do_edge, lead, din, load, pop, f_vld;
   logic [7:0]         ld_byte, f_data;

   // Transmit queue
   spc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
      .clk_in        (clk_in),
      .srst_in       (srst_in),
      .in_valid_in   (tx_valid_in),
      .in_ready_out  (tx_ready_out),
      .in_data_in    (tx_data_in),
      .out_valid_out (f_vld),
      .out_ready_in  (pop),
      .out_data_out  (f_data)
   );

   // Next state
   always_comb begin
      n        = st;
      stp      = '0;
      do_edge  = 1'b0;
      lead     = 1'b0;
      din      = 1'b0;
      load     = 1'b0;
      pop      = 1'b0;
      ld_byte  = f_data;
      n.rx_vld = 1'b0;
      if (peer_master_in) begin
         din = link.miso;
         if (st.active) begin
            // Toggle the clock each half period
            if (st.tick == HALF - 8'h01) begin
               n.tick  = 8'h00;
               n.sclk  = ~st.sclk;
               do_edge = 1'b1;
               lead    = ~st.edges[0];
            end else begin
               n.tick = st.tick + 8'h01;
            end
         end else if (st.gap) begin
            // Hold select, then raise it between bytes when needed
            if (st.tick == HALF - 8'h01) begin
               n.tick = 8'h00;
               if (!st.ss_n && (!cpha_in || !f_vld)) begin
                  n.ss_n = 1'b1;
               end else begin
                  n.gap = 1'b0;
               end
            end else begin
               n.tick = st.tick + 8'h01;
            end
         end else if (f_vld) begin
            pop    = 1'b1;
            load   = 1'b1;
            n.ss_n = 1'b0;
         end
      end else begin
         // Slave: follow the select and clock lines
         din    = link.mosi;
         lead   = (link.sclk != cpol_in);
         n.ss_n = 1'b1;
         if (link.ss_n) begin
            n.active = 1'b0;
            n.edges  = 4'h0;
            n.gap    = 1'b0;
         end else begin
            load    = !st.active && !st.gap;
            pop     = load & f_vld;
            ld_byte = f_vld ? f_data : IDLE_FILL;
            do_edge = (link.sclk != st.sclk_prev);
         end
      end
      // Start a byte
      if (load) begin
         n.shift  = ld_byte;
         n.dout   = ld_byte[7];
         n.active = 1'b1;
         n.tick   = 8'h00;
         n.edges  = 4'h0;
      end
      // Shift; the sixteenth edge ends the byte
      if (do_edge && n.active) begin
         stp                       = spc_step({n.shift, n.samp, n.dout}, cpha_in, lead, din);
         {n.shift, n.samp, n.dout} = stp;
         if (n.edges == LAST_EDGE) begin
            n.rx_vld  = 1'b1;
            n.rx_data = n.shift;
            n.active  = 1'b0;
            n.edges   = 4'h0;
            n.tick    = 8'h00;
            n.gap     = peer_master_in | ~cpha_in;
         end else begin
            n.edges = n.edges + 4'h1;
         end
      end
      if (!n.active) begin
         n.sclk = cpol_in;
      end
      n.sclk_prev = link.sclk;
      if (srst_in) begin
         n      = '0;
         n.ss_n = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      st <= n;
   end

   // Outputs and pin drives
   assign rx_valid_out      = st.rx_vld;
   assign rx_data_out       = st.rx_data;
   assign link.peer_sclk_o  = st.sclk;
   assign link.peer_sclk_oe = peer_master_in;
   assign link.peer_mosi_o  = st.dout;
   assign link.peer_mosi_oe = peer_master_in;
   assign link.peer_miso_o  = st.dout;
   assign link.peer_miso_oe = ~peer_master_in & ~link.ss_n;
   assign link.peer_ss_o    = st.ss_n;
   assign link.peer_ss_oe   = peer_master_in;
endmodule : spc_peer
`default_nettype wire

// ### testbench/spc_link_monitor.sv
// Checker on the link wires
`timescale 1ns/1ns
`default_nettype none
module spc_link_monitor (
   // Clock, reset and wires
   input wire logic clk_in, srst_in, sclk, ss_n,
   input wire logic dev_sclk_oe, dev_miso_oe, dev_ss_oe, peer_sclk_oe, peer_ss_oe
);
   // ==========================================
   // Edges counted inside a select frame
   logic [7:0] edges_reg;
   logic       sclk_reg;
   always_ff @(posedge clk_in) begin
      sclk_reg  <= sclk;
      edges_reg <= (srst_in | ss_n) ? 8'h00 : edges_reg + 8'(sclk ^ sclk_reg);
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // Peer clock held for the rest of its half period
   sequence s_hold;
      (!peer_sclk_oe || $stable(sclk))[*3];
   endsequence
   a_miso_off_idle: assert property (ss_n && $past(ss_n) && $past(ss_n, 2) |-> !dev_miso_oe)
      else $error("miso on");
   a_miso_on_select: assert property ($fell(ss_n) && peer_sclk_oe |-> ##[1:4] dev_miso_oe)
      else $error("miso off");
   a_one_clock_owner: assert property (!(dev_sclk_oe && peer_sclk_oe))
      else $error("clock clash");
   a_slave_ss_input: assert property (dev_miso_oe |-> !dev_ss_oe && !dev_sclk_oe)
      else $error("slave drives");
   a_frame_edge_count: assert property ($rose(ss_n) && peer_ss_oe |-> edges_reg == 8'h10)
      else $error("edge count");
   a_idle_clock_level: assert property (peer_sclk_oe && $past(peer_sclk_oe) && ss_n |-> $stable(sclk))
      else $error("idle clock");
   a_peer_half_period: assert property ($changed(sclk) && peer_sclk_oe && $past(peer_sclk_oe) |=> s_hold)
      else $error("peer rate");
   a_dev_rate_floor: assert property ($changed(sclk) && dev_sclk_oe && $past(dev_sclk_oe) |=> $stable(sclk))
      else $error("master rate");
endmodule : spc_link_monitor
`default_nettype wire

// ### testbench/spi_pin_and_register_control_tb.sv
// Bench for the SPI device and its peer on one link
`timescale 1ns/1ns
`default_nettype none
module spi_pin_and_register_control_tb
   import spc_pkg::*;
;
   // ==========================================
   // Drives, captures and counts
   logic       clk_in = 1'b0, srst_in = 1'b1, wr = 1'b0, rd = 1'b0, pm = 1'b0;
   logic       cpha = 1'b1, tv = 1'b0, sel = 1'b0, prv, rxq, txq, ssd;
   logic [1:0] addr = 2'h0;
   logic [7:0] wd = 8'h00, td = 8'h00, rdata, got, prx, s, r, d [5];
   int         err_total = 0, tests_run = 0, n_rx = 0;
   spc_link_if lk ();
   always #50 clk_in = ~clk_in;
   // Peer receive pulses
   always @(posedge clk_in) if (prv) begin
      got <= prx;
      n_rx <= n_rx + 1;
   end
   spc_device spc_device_inst (.clk_in, .srst_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wd), .reg_rdata_out(rdata), .rx_irq_out(rxq), .tx_irq_out(txq), .ss_gpio_in(1'b0),
      .ss_gpio_oe_in(sel), .ss_dedicated_out(ssd), .link(lk.dev));
   spc_peer spc_peer_inst (.clk_in, .srst_in, .peer_master_in(pm), .cpol_in(1'b0), .cpha_in(cpha),
      .tx_valid_in(tv), .tx_ready_out(), .tx_data_in(td), .rx_valid_out(prv), .rx_data_out(prx), .link(lk.peer));
   spc_link_monitor spc_link_monitor_inst (.clk_in, .srst_in, .sclk(lk.sclk), .ss_n(lk.ss_n),
      .dev_sclk_oe(lk.dev_sclk_oe), .dev_miso_oe(lk.dev_miso_oe), .dev_ss_oe(lk.dev_ss_oe),
      .peer_sclk_oe(lk.peer_sclk_oe), .peer_ss_oe(lk.peer_ss_oe));
   task automatic chk(input string nm, input logic [7:0] e, a);
      tests_run++;
      if (a !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, a);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // One register cycle; read answer lands in s
   task automatic reg_op(input logic w, input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_in);
      wr <= w;
      rd <= !w;
      addr <= a;
      wd <= v;
      @(posedge clk_in);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 s = rdata;
   endtask : reg_op
   task automatic rdchk(input string nm, input logic [1:0] a, input logic [7:0] e);
      reg_op(1'b0, a, 8'h00);
      chk(nm, e, s);
   endtask : rdchk
   task automatic push(input logic [7:0] v);
      @(posedge clk_in);
      tv <= 1'b1;
      td <= v;
      @(posedge clk_in);
      tv <= 1'b0;
   endtask : push
   task automatic wait_rx(input int n);
      for (int i = 0; i < 5000 && n_rx < n; i++) @(posedge clk_in);
      if (n_rx < n) begin
         err_total++;
         give_verdict();
      end
      repeat (4) @(posedge clk_in);
   endtask : wait_rx
   // Device as master, peer answers the inverse
   task automatic xfer(input logic [7:0] v);
      push(~v);
      sel <= 1'b1;
      reg_op(1'b1, REG_DATA, v);
      wait_rx(n_rx + 1);
      sel <= 1'b0;
      chk("peer byte", v, got);
   endtask : xfer
   initial begin
      void'($urandom(51));
      r = 8'($urandom % 4);
      foreach (d[i]) d[i] = 8'($urandom);
      d[0] = 8'h01;
      repeat (6) @(posedge clk_in);
      srst_in <= 1'b0;
      rdchk("ctrl", REG_CTRL, CTRL_RST);
      rdchk("status", REG_STAT, STAT_RST);
      rdchk("unmapped", 2'h3, 8'h00);
      reg_op(1'b1, REG_STAT, r);
      reg_op(1'b1, REG_CTRL, 8'h2a);
      chk("requests", 8'h00, {5'h00, rxq, txq, ssd});
      xfer(d[0]);
      rdchk("full", REG_STAT, 8'h88 | r);
      rdchk("rx", REG_DATA, ~d[0]);
      xfer(d[1]);
      xfer(d[2]);
      rdchk("overflow", REG_STAT, 8'ha8 | r);
      rdchk("kept", REG_DATA, ~d[1]);
      rdchk("cleared", REG_STAT, 8'h08 | r);
      reg_op(1'b1, REG_CTRL, 8'h02);
      reg_op(1'b1, REG_STAT, 8'h44);
      push(d[3]);
      cpha <= 1'b0;
      pm <= 1'b1;
      wait_rx(n_rx + 1);
      chk("old tx", d[2], got);
      rdchk("slave rx", REG_DATA, d[3]);
      push(d[4]);
      repeat (20) @(posedge clk_in);
      pm <= 1'b0;
      repeat (4) @(posedge clk_in);
      rdchk("fault", REG_STAT, 8'hdc);
      chk("requests", 8'h05, {5'h00, rxq, txq, ssd});
      reg_op(1'b1, REG_CTRL, 8'h83);
      rdchk("unfaulted", REG_STAT, 8'hcc);
      chk("requests", 8'h07, {5'h00, rxq, txq, ssd});
      give_verdict();
   end
endmodule : spi_pin_and_register_control_tb
`default_nettype wire
